//--- hw/pcm_cr_mask.v
// implemented-bit masks for the control register select codes
`timescale 1ns/1ps
module pcm_cr_mask #(
  parameter NUM_CR = 4
) (
  input wire [12*NUM_CR-1:0] cr_codes_in,
  input wire [32*NUM_CR-1:0] cr_masks_in,
  input wire [11:0] sel_in,
  output wire hit_out,
  output wire [NUM_CR-1:0] onehot_out,
  output wire [31:0] mask_out
);
  wire [32*NUM_CR-1:0] part;
  genvar i;
  generate
    for (i = 0; i < NUM_CR; i = i + 1)
    begin : g_cr
      assign onehot_out[i] = (cr_codes_in[12*i +: 12] == sel_in);
      assign part[32*i +: 32] = onehot_out[i] ? cr_masks_in[32*i +: 32] : 32'h00000000;
    end
  endgenerate
  reg [31:0] acc;
  integer k;
  always @*
  begin
    acc = 32'h00000000;
    for (k = 0; k < NUM_CR; k = k + 1)
      acc = acc | part[32*k +: 32];
  end
  assign mask_out = acc;
  assign hit_out = |onehot_out;
endmodule

//--- hw/pcm_regs.vh
// constants for the privileged control-register move and physical lookup unit
`ifndef PCM_REGS_VH
`define PCM_REGS_VH
`define PCM_EXT_TYPE_BIT 15
`define PCM_EXT_REG_HI 14
`define PCM_EXT_REG_LO 12
`define PCM_EXT_CR_HI 11
`define PCM_EXT_CR_LO 0
`define PCM_DIR_CR_TO_GR 1'b0
`define PCM_DIR_GR_TO_CR 1'b1
`define PCM_TYPE_DATA 1'b0
`define PCM_TYPE_ADDR 1'b1
`define PCM_TC_EN_ON 1'b1
`define PCM_WORD_ZERO 32'h00000000
`define PCM_FLT_NONE 2'h0
`define PCM_FLT_PRIV 2'h1
`define PCM_FLT_ACCESS 2'h2
`endif

//--- hw/pcm_top.v
// execution unit for the control-register move and physical address lookup
//
// Overview of operation
// [RULE1] control-register move runs only in supervisor state, else trap
// [RULE2] control-register move always transfers a full 32-bit word
// [RULE3] unimplemented control register bits read back as zero
// [RULE4] direction 0 copies control to general, 1 general to control
// [RULE5] type bit 0 selects data register, 1 selects address register
// [RULE6] extension: bit15 type, bits14-12 register, bits11-0 control select
// [RULE7] physical lookup is privileged; user mode raises privilege violation
// [RULE8] lookup translates function code plus address, loads 32-bit result
// [RULE9] lookup checks all access errors incl. read/write variant, faults
// [RULE10] transparent translation hit keeps address register unchanged
// [RULE11] translation off or mmu disabled uses default, address unchanged
// [RULE12] enabled, not disabled, cache hit loads cached physical address
// [RULE13] cache miss walks tables; valid page updates cache, else fault
// [RULE14] system asserts mmu disable to force default transparent mode
`timescale 1ns/1ps
`include "pcm_regs.vh"
module pcm_top #(
  parameter NUM_CR = 4,
  parameter [12*NUM_CR-1:0] CR_CODES = {12'h803, 12'h003, 12'h002, 12'h000},
  parameter [32*NUM_CR-1:0] CR_MASKS = {32'hffffffff, 32'h0000ffff, 32'hffffffff,
                                        32'h00000007}
) (
  input wire clk_in,
  input wire sys_rst_in,
  input wire supervisor_in,
  // control register move request
  input wire move_start_in,
  input wire transfer_direction_bit_in,
  input wire [15:0] ext_word_in,
  input wire [31:0] general_register_value_in,
  input wire [31:0] control_register_value_in,
  // physical lookup request
  input wire lookup_start_in,
  input wire physical_lookup_write_variant_in,
  input wire [2:0] address_register_num_in,
  input wire [31:0] address_register_value_in,
  input wire [2:0] destination_function_code_in,
  input wire transparent_translation_hit_in,
  input wire translation_enable_in,
  input wire mmu_disable_input_in,
  input wire address_translation_cache_hit_in,
  input wire [31:0] address_translation_cache_pa_in,
  input wire cache_access_fault_in,
  input wire walk_done_in,
  input wire walk_valid_in,
  input wire walk_fault_in,
  input wire [31:0] walk_pa_in,
  // outputs
  output reg busy_out,
  output reg done_out,
  output reg [1:0] fault_out,
  output reg gr_write_out,
  output reg gr_is_addr_out,
  output reg [2:0] gr_num_out,
  output reg [31:0] gr_data_out,
  output reg cr_write_out,
  output reg [11:0] cr_sel_out,
  output reg [31:0] cr_data_out,
  output reg lookup_req_out,
  output reg [2:0] lookup_fc_out,
  output reg [31:0] lookup_addr_out,
  output reg lookup_write_out,
  output reg walk_start_out,
  output reg cache_update_out,
  output reg [31:0] cache_update_pa_out
);
  localparam ST_IDLE = 3'b001;
  localparam ST_PROBE = 3'b010;
  localparam ST_WALK = 3'b100;

  reg [2:0] state_q;
  reg [2:0] an_q;
  reg [31:0] la_q;
  reg mmu_disable_input_m1_q, mmu_disable_input_m2_q, mmu_disable_input_m3_q, mmu_disable_input_q;

  wire [11:0] sel = ext_word_in[`PCM_EXT_CR_HI:`PCM_EXT_CR_LO]; // [RULE6]
  wire cr_hit;
  wire [31:0] cr_mask;

  pcm_cr_mask #(.NUM_CR(NUM_CR)) u_mask (
    .cr_codes_in(CR_CODES),
    .cr_masks_in(CR_MASKS),
    .sel_in(sel),
    .hit_out(cr_hit),
    .onehot_out(),
    .mask_out(cr_mask)
  );

  // pin synchroniser: change counts once stages two and three agree
  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      mmu_disable_input_m1_q <= 1'b0;
      mmu_disable_input_m2_q <= 1'b0;
      mmu_disable_input_m3_q <= 1'b0;
      mmu_disable_input_q <= 1'b0;
    end
    else
    begin
      mmu_disable_input_m1_q <= mmu_disable_input_in;
      mmu_disable_input_m2_q <= mmu_disable_input_m1_q;
      mmu_disable_input_m3_q <= mmu_disable_input_m2_q;
      if (mmu_disable_input_m2_q == mmu_disable_input_m3_q)
        mmu_disable_input_q <= mmu_disable_input_m3_q; // [RULE14]
    end
  end

  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      state_q <= ST_IDLE;
      an_q <= 3'h0;
      la_q <= `PCM_WORD_ZERO;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      fault_out <= `PCM_FLT_NONE;
      gr_write_out <= 1'b0;
      gr_is_addr_out <= 1'b0;
      gr_num_out <= 3'h0;
      gr_data_out <= `PCM_WORD_ZERO;
      cr_write_out <= 1'b0;
      cr_sel_out <= 12'h000;
      cr_data_out <= `PCM_WORD_ZERO;
      lookup_req_out <= 1'b0;
      lookup_fc_out <= 3'h0;
      lookup_addr_out <= `PCM_WORD_ZERO;
      lookup_write_out <= 1'b0;
      walk_start_out <= 1'b0;
      cache_update_out <= 1'b0;
      cache_update_pa_out <= `PCM_WORD_ZERO;
    end
    else
    begin
      done_out <= 1'b0;
      fault_out <= `PCM_FLT_NONE;
      gr_write_out <= 1'b0;
      cr_write_out <= 1'b0;
      lookup_req_out <= 1'b0;
      walk_start_out <= 1'b0;
      cache_update_out <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (move_start_in)
          begin
            done_out <= 1'b1;
            if (!supervisor_in)
              fault_out <= `PCM_FLT_PRIV; // [RULE1]
            else if (transfer_direction_bit_in == `PCM_DIR_CR_TO_GR)
            begin
              // [RULE4] [RULE5] [RULE6]
              gr_write_out <= 1'b1;
              gr_is_addr_out <= (ext_word_in[`PCM_EXT_TYPE_BIT] == `PCM_TYPE_ADDR);
              gr_num_out <= ext_word_in[`PCM_EXT_REG_HI:`PCM_EXT_REG_LO];
              gr_data_out <= control_register_value_in & cr_mask; // [RULE2] [RULE3]
            end
            else
            begin
              // unknown select codes write nothing
              cr_write_out <= cr_hit; // [RULE4]
              cr_sel_out <= sel;
              cr_data_out <= general_register_value_in; // [RULE2]
            end
          end
          else if (lookup_start_in)
          begin
            if (!supervisor_in)
            begin
              done_out <= 1'b1;
              fault_out <= `PCM_FLT_PRIV; // [RULE7]
            end
            else
            begin
              busy_out <= 1'b1;
              an_q <= address_register_num_in;
              la_q <= address_register_value_in;
              lookup_req_out <= 1'b1; // [RULE8]
              lookup_fc_out <= destination_function_code_in;
              lookup_addr_out <= address_register_value_in;
              lookup_write_out <= physical_lookup_write_variant_in; // [RULE9]
              state_q <= ST_PROBE;
            end
          end
        end
        ST_PROBE:
        begin
          gr_is_addr_out <= `PCM_TYPE_ADDR;
          gr_num_out <= an_q;
          if (cache_access_fault_in)
          begin
            fault_out <= `PCM_FLT_ACCESS; // [RULE9]
            done_out <= 1'b1;
            busy_out <= 1'b0;
            state_q <= ST_IDLE;
          end
          else if (transparent_translation_hit_in ||
                   translation_enable_in != `PCM_TC_EN_ON || mmu_disable_input_q)
          begin
            // [RULE10] [RULE11] address register left as is
            gr_write_out <= 1'b1;
            gr_data_out <= la_q;
            done_out <= 1'b1;
            busy_out <= 1'b0;
            state_q <= ST_IDLE;
          end
          else if (address_translation_cache_hit_in)
          begin
            gr_write_out <= 1'b1;
            gr_data_out <= address_translation_cache_pa_in; // [RULE12]
            done_out <= 1'b1;
            busy_out <= 1'b0;
            state_q <= ST_IDLE;
          end
          else
          begin
            walk_start_out <= 1'b1; // [RULE13]
            state_q <= ST_WALK;
          end
        end
        ST_WALK:
        begin
          if (walk_done_in)
          begin
            done_out <= 1'b1;
            busy_out <= 1'b0;
            state_q <= ST_IDLE;
            if (walk_valid_in && !walk_fault_in)
            begin
              cache_update_out <= 1'b1; // [RULE13]
              cache_update_pa_out <= walk_pa_in;
              gr_write_out <= 1'b1;
              gr_data_out <= walk_pa_in;
            end
            else
              fault_out <= `PCM_FLT_ACCESS; // [RULE13] [RULE9]
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
          busy_out <= 1'b0;
        end
      endcase
    end
  end
endmodule

//--- sim/pcm_top_properties.sv
// timing checks on the move and lookup unit ports
`timescale 1ns/1ps
module pcm_chk (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic supervisor_in,
  input wire logic move_start_in,
  input wire logic lookup_start_in,
  input wire logic transfer_direction_bit_in,
  input wire logic [15:0] ext_word_in,
  input wire logic walk_done_in,
  input wire logic walk_valid_in,
  input wire logic walk_fault_in,
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic [1:0] fault_out,
  input wire logic gr_write_out,
  input wire logic gr_is_addr_out,
  input wire logic [2:0] gr_num_out,
  input wire logic cr_write_out,
  input wire logic lookup_req_out,
  input wire logic walk_start_out,
  input wire logic cache_update_out
);
  logic [15:0] ext_q;
  logic mv_s, lk_s;
  logic walk_q, walking;
  always_ff @(posedge clk_in) ext_q <= ext_word_in;
  // table walk outstanding: from walk_start_out until the done pulse
  always_ff @(posedge clk_in) walk_q <= !sys_rst_in && (walk_start_out || (walk_q && !done_out));
  assign walking = walk_start_out || walk_q;
  assign mv_s = move_start_in && !busy_out;
  assign lk_s = lookup_start_in && !move_start_in && !busy_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  a_user_move_trap: assert property (mv_s && !supervisor_in |=> done_out && fault_out == 2'h1
    && !gr_write_out && !cr_write_out) else $error("user move not trapped");
  a_move_read_dir: assert property (mv_s && supervisor_in && !transfer_direction_bit_in
    |=> done_out && gr_write_out && !cr_write_out) else $error("read move wrong");
  a_move_reg_sel: assert property (mv_s && supervisor_in && !transfer_direction_bit_in
    |=> gr_is_addr_out == ext_q[15] && gr_num_out == ext_q[14:12]) else $error("bad reg select");
  a_cr_write_cause: assert property (cr_write_out |-> $past(move_start_in)
    && $past(transfer_direction_bit_in) && $past(supervisor_in)) else $error("stray cr write");
  a_user_lookup_priv: assert property (lk_s && !supervisor_in |=> done_out
    && fault_out == 2'h1 && !lookup_req_out) else $error("user lookup not refused");
  a_lookup_probe: assert property (lk_s && supervisor_in |=> lookup_req_out && busy_out)
    else $error("lookup not started");
  a_walk_good: assert property (busy_out && walking && walk_done_in && walk_valid_in
    && !walk_fault_in |=> done_out && gr_write_out && cache_update_out && fault_out == 2'h0)
    else $error("walk");
  a_walk_bad: assert property (busy_out && walking && walk_done_in && !walk_valid_in
    |=> done_out && fault_out == 2'h2 && !gr_write_out) else $error("walk fault lost");
endmodule
bind pcm_top pcm_chk CHK (.*);

//--- sim/tb.sv
// self-checking bench for the move and lookup unit
`timescale 1ns/1ps
module tb;
  typedef struct packed {logic dir; logic [15:0] ext; logic [31:0] v, e;} pcm_mv_t;
  logic clk_in = 0, sys_rst_in = 1, supervisor_in = 0, move_start_in = 0;
  logic transfer_direction_bit_in = 0, lookup_start_in = 0;
  logic physical_lookup_write_variant_in = 0, transparent_translation_hit_in = 0;
  logic translation_enable_in = 0, mmu_disable_input_in = 0, cache_access_fault_in = 0;
  logic address_translation_cache_hit_in = 0, walk_done_in = 0, walk_valid_in = 0;
  logic walk_fault_in = 0, busy_out, done_out, gr_write_out, gr_is_addr_out, cr_write_out;
  logic lookup_req_out, lookup_write_out, walk_start_out, cache_update_out;
  logic [15:0] ext_word_in = 0;
  logic [2:0] address_register_num_in = 3'h4, destination_function_code_in = 0;
  logic [2:0] gr_num_out, lookup_fc_out;
  logic [1:0] fault_out;
  logic [11:0] cr_sel_out;
  logic [31:0] general_register_value_in = 0, control_register_value_in = 0;
  logic [31:0] address_register_value_in = 32'h13579bd0, gr_data_out, cr_data_out;
  logic [31:0] address_translation_cache_pa_in = 32'h0abcd000, walk_pa_in = 32'h0fedc000;
  logic [31:0] lookup_addr_out, cache_update_pa_out;
  int errors = 0, checked = 0;
  pcm_mv_t rows[6] = '{'{1'h0, 16'h2000, 32'hffffffff, 32'h7}, '{1'h0, 16'hd003, 32'h12345678,
    32'h5678}, '{1'h0, 16'h7803, 32'hdeadbeef, 32'hdeadbeef}, '{1'h0, 16'h07ff, 32'hffffffff,
    32'h0}, '{1'h1, 16'h1002, 32'ha5a5a5a5, 32'ha5a5a5a5}, '{1'h1, 16'hb003, 32'hcafe1234,
    32'hcafe1234}};
  pcm_top DUT (.*);
  always #12.5 clk_in = ~clk_in;
  task automatic check(input logic [63:0] s, input logic [63:0] e);
    checked++;
    if (s !== e)
    begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic close_out;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // c = {sup, tt, en, hit, flt, write}
  task automatic lk(input logic [5:0] c, input logic [31:0] exp, input logic [1:0] ef);
    @(posedge clk_in);
    {supervisor_in, transparent_translation_hit_in, translation_enable_in} <= c[5:3];
    {address_translation_cache_hit_in, cache_access_fault_in} <= c[2:1];
    physical_lookup_write_variant_in <= c[0];
    destination_function_code_in <= c[2:0];
    lookup_start_in <= 1;
    @(posedge clk_in);
    lookup_start_in <= 0;
    #1;
    if (c[5])
    begin
      check(lookup_addr_out, 32'h13579bd0);
      check(lookup_fc_out, c[2:0]);
      check(lookup_write_out, c[0]);
      @(posedge clk_in);
      #1;
    end
    if (c[5:1] == 5'h14)
    begin
      check(walk_start_out, 1'h1);
      @(posedge clk_in);
      {walk_done_in, walk_valid_in, walk_fault_in} <= {1'h1, c[0], !c[0]};
      @(posedge clk_in);
      walk_done_in <= 0;
      #1;
      check(cache_update_out, c[0]);
      if (c[0])
        check(cache_update_pa_out, 32'h0fedc000);
    end
    check(done_out, 1'h1);
    check(fault_out, ef);
    if (ef == 0)
      check({gr_write_out, gr_is_addr_out, gr_num_out, gr_data_out},
        {2'h3, 3'h4, exp});
  endtask
  initial
  begin
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 0;
    foreach (rows[i])
    begin
      @(posedge clk_in);
      {move_start_in, supervisor_in, transfer_direction_bit_in} <= {2'h3, rows[i].dir};
      ext_word_in <= rows[i].ext;
      general_register_value_in <= rows[i].v;
      control_register_value_in <= rows[i].v;
      @(posedge clk_in);
      move_start_in <= 0;
      #1;
      check(done_out, 1'h1);
      if (!rows[i].dir)
        check({gr_write_out, gr_is_addr_out, gr_num_out, gr_data_out},
          {1'h1, rows[i].ext[15:12], rows[i].e});
      else
        check({cr_write_out, cr_sel_out, cr_data_out},
          {1'h1, rows[i].ext[11:0], rows[i].e});
    end
    @(posedge clk_in);
    {move_start_in, supervisor_in} <= 2'h2;
    @(posedge clk_in);
    move_start_in <= 0;
    #1;
    check({fault_out, gr_write_out, cr_write_out}, 4'h4);
    lk(6'h00, 32'h0, 2'h1);
    lk(6'h38, 32'h13579bd0, 2'h0);
    lk(6'h24, 32'h13579bd0, 2'h0);
    lk(6'h2c, 32'h0abcd000, 2'h0);
    lk(6'h2f, 32'h0, 2'h2);
    lk(6'h29, 32'h0fedc000, 2'h0);
    lk(6'h28, 32'h0, 2'h2);
    @(posedge clk_in);
    mmu_disable_input_in <= 1;
    repeat (5) @(posedge clk_in);
    lk(6'h2c, 32'h13579bd0, 2'h0);
    // reset in mid-lookup, then a move right after release
    @(posedge clk_in);
    {lookup_start_in, supervisor_in} <= 2'h3;
    @(posedge clk_in);
    {lookup_start_in, sys_rst_in} <= 2'h1;
    #1;
    check(busy_out, 1'h1);
    @(posedge clk_in);
    sys_rst_in <= 0;
    #1;
    check({busy_out, done_out, gr_write_out, fault_out}, 5'h0);
    @(posedge clk_in);
    {move_start_in, transfer_direction_bit_in} <= 2'h2;
    @(posedge clk_in);
    move_start_in <= 0;
    #1;
    check({gr_write_out, gr_num_out, gr_data_out}, {4'hb, 32'h00001234});
    close_out;
  end
  initial
  begin
    repeat (2000) @(posedge clk_in);
    errors++;
    close_out;
  end
endmodule
